// file: pwrseq_top.v
// Purpose: power on/off sequencer with AHB-Lite register slave
// Assumes: inputs synchronous to REF_CLK; zero-wait AHB-Lite slave
// Notes:
// Summary of operation
// - Switch rising edge starts power-on, enabling the logic rail.
// - Time of day equal to programmed wake time powers system on.
// - Switch falling edge starts the power-off routine.
// - Low battery interrupts main CPU; CPU then stops work cleanly.
// - Low-battery warning stays shown for thirty seconds.
// - After warning, power goes off if switch is still on.
// - Idle in key entry for auto-off interval powers off; default ten.
// - Auto-off interval programmable from 1 to 255 minutes.
// - Off unloads head, then cuts tape, prom, serial, barcode, speaker.
// - On/off requests handled as events; rail changes follow with delay.
// - Running operations finish and printer reinit before rail drops.
// - Drive off signal to gate arrays across power transitions.
// - With adapter present, choose normal or trickle charging.
// - Sample battery through ADC for low detect and charge mode.
// - Measured voltage returns charging from trickle to normal.
// - Line-driver supply on only while either serial port in use.
// - Program-memory regulator on only while that memory accessed.
// - Display bias supply on whenever system power is on.
// - Power enable output low means rail on, high means off.
// - Gate-array off output active low; acts as reset only.
// - Backup select high picks auxiliary battery, low picks main.
`timescale 1ns/1ps
`include "pwrseq_regs.vh"

module pwrseq_top #(
    parameter SEC_CYC = `PWRSEQ_SEC_CYC
) (
    input  wire        REF_CLK,
    input  wire        RST_B,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    input  wire        POWER_SWITCH_IRQ_INPUT,
    input  wire        ADAPTER_PRESENT,
    input  wire [5:0]  BATTERY_RAIL,
    input  wire        IO_ACTIVITY,
    input  wire        KEY_ENTRY_WAIT,
    input  wire        OP_BUSY,
    input  wire        PRINTER_READY,
    output reg         POWER_ENABLE_OUTPUT_B,
    output reg         GATE_ARRAY_INIT_OUTPUT_B,
    output reg         BACKUP_SOURCE_SELECT,
    output reg         CHARGE_TRICKLE,
    output reg         LOW_BATT_IRQ,
    output reg         POWER_OFF_IRQ,
    output reg         WARN_DISPLAY,
    output reg         HEAD_UNLOAD,
    output reg         PERIPH_POWER,
    output reg         LINE_DRIVER_EN,
    output reg         PROM_REG_EN,
    output reg         LCD_BIAS_EN,
    output reg         ADC_SAMPLE
);
    ////////////////////////////////////////////////////////////////////
    // Bus slave
    reg  [7:0]  ctrl;
    reg  [16:0] wake_time;
    reg  [7:0]  autooff_min;
    reg  [5:0]  vlow_thr;
    reg  [5:0]  vrech_thr;
    reg         wr_pend;
    reg  [11:0] wr_addr;
    reg         tod_load;
    reg  [16:0] tod_wr;
    reg         ack_req;
    wire        sec_tick;
    wire [16:0] tod;
    reg  [2:0]  state;
    reg  [5:0]  vbat;
    reg         low_seen;

    wire take = HSEL && HREADY && HTRANS[1];

    function [31:0] rd_mux;
        input [11:0] a;
        begin
            if (a == `PWRSEQ_CTRL_OFS)
                rd_mux = {24'h000000, ctrl};
            else if (a == `PWRSEQ_STATUS_OFS)
                rd_mux = {20'h00000, vbat, low_seen, CHARGE_TRICKLE,
                          POWER_SWITCH_IRQ_INPUT, state};
            else if (a == `PWRSEQ_WAKE_OFS)
                rd_mux = {15'h0000, wake_time};
            else if (a == `PWRSEQ_TOD_OFS)
                rd_mux = {15'h0000, tod};
            else if (a == `PWRSEQ_AUTOOFF_OFS)
                rd_mux = {24'h000000, autooff_min};
            else if (a == `PWRSEQ_VTHR_OFS)
                rd_mux = {18'h00000, vrech_thr, 2'h0, vlow_thr};
            else
                rd_mux = 32'h00000000;
        end
    endfunction

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            HRDATA      <= 32'h00000000;
            HREADYOUT   <= 1'b1;
            HRESP       <= 1'b0;
            wr_pend     <= 1'b0;
            wr_addr     <= 12'h000;
            ctrl        <= `PWRSEQ_CTRL_RESET;
            wake_time   <= 17'h00000;
            autooff_min <= `PWRSEQ_AUTOOFF_RESET;
            vlow_thr    <= `PWRSEQ_VLOW_RESET;
            vrech_thr   <= `PWRSEQ_VRECH_RESET;
            tod_load    <= 1'b0;
            tod_wr      <= 17'h00000;
            ack_req     <= 1'b0;
        end else begin
            tod_load <= 1'b0;
            ack_req  <= 1'b0;
            wr_pend  <= take && HWRITE;
            if (take) begin
                wr_addr <= HADDR[11:0];
                if (!HWRITE)
                    HRDATA <= rd_mux(HADDR[11:0]);
            end
            if (wr_pend) begin
                if (wr_addr == `PWRSEQ_CTRL_OFS)
                    ctrl <= HWDATA[7:0];
                else if (wr_addr == `PWRSEQ_WAKE_OFS)
                    wake_time <= HWDATA[16:0];
                else if (wr_addr == `PWRSEQ_TOD_OFS) begin
                    // Hold the new time: HWDATA is gone after this phase
                    tod_load <= 1'b1;
                    tod_wr   <= HWDATA[16:0];
                end else if (wr_addr == `PWRSEQ_AUTOOFF_OFS) begin
                    if (HWDATA[7:0] != 8'h00)
                        autooff_min <= HWDATA[7:0];
                end else if (wr_addr == `PWRSEQ_VTHR_OFS) begin
                    vlow_thr  <= HWDATA[5:0];
                    vrech_thr <= HWDATA[13:8];
                end else if (wr_addr == `PWRSEQ_ACK_OFS)
                    ack_req <= HWDATA[0];
            end
        end
    end

    pwrseq_timebase #(
        .SEC_CYC (SEC_CYC)
    ) u_timebase (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .tod_load  (tod_load),
        .tod_value (tod_wr),
        .sec_tick  (sec_tick),
        .tod       (tod)
    );

    ////////////////////////////////////////////////////////////////////
    // Switch edges, battery sampling, idle and warning timers
    reg        sw_q;
    reg        adc_phase;
    reg [5:0]  idle_sec;
    reg [7:0]  idle_min;
    reg [4:0]  warn_sec;
    reg [3:0]  step;
    reg        wake_hit;

    wire sw_rise = POWER_SWITCH_IRQ_INPUT && !sw_q;
    wire sw_fall = !POWER_SWITCH_IRQ_INPUT && sw_q;
    wire rail_on = (state == `PWRSEQ_S_RAILON) || (state == `PWRSEQ_S_ON) ||
                   (state == `PWRSEQ_S_WARN) || (state == `PWRSEQ_S_REQ) ||
                   (state == `PWRSEQ_S_HEAD) || (state == `PWRSEQ_S_PERIPH);
    wire idle_expired = (idle_min >= autooff_min);

    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sw_q       <= 1'b0;
            adc_phase  <= 1'b0;
            vbat       <= 6'h3F;
            ADC_SAMPLE <= 1'b0;
            idle_sec   <= 6'h00;
            idle_min   <= 8'h00;
            wake_hit   <= 1'b0;
        end else begin
            sw_q <= POWER_SWITCH_IRQ_INPUT;
            // Once a second: enable divider, then latch reading
            ADC_SAMPLE <= sec_tick;
            adc_phase  <= ADC_SAMPLE;
            if (adc_phase)
                vbat <= BATTERY_RAIL;
            wake_hit <= ctrl[`PWRSEQ_CTRL_WAKE_EN] && sec_tick &&
                        (tod == wake_time);
            if (IO_ACTIVITY || !KEY_ENTRY_WAIT ||
                state != `PWRSEQ_S_ON) begin
                idle_sec <= 6'h00;
                idle_min <= 8'h00;
            end else if (sec_tick && !idle_expired) begin
                if (idle_sec == `PWRSEQ_MIN_S - 1) begin
                    idle_sec <= 6'h00;
                    idle_min <= idle_min + 8'h01;
                end else begin
                    idle_sec <= idle_sec + 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power sequencer
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state                    <= `PWRSEQ_S_OFF;
            warn_sec                 <= 5'h00;
            step                     <= 4'h0;
            low_seen                 <= 1'b0;
            POWER_ENABLE_OUTPUT_B    <= 1'b1;
            GATE_ARRAY_INIT_OUTPUT_B <= 1'b0;
            LOW_BATT_IRQ             <= 1'b0;
            POWER_OFF_IRQ            <= 1'b0;
            WARN_DISPLAY             <= 1'b0;
            HEAD_UNLOAD              <= 1'b0;
            PERIPH_POWER             <= 1'b0;
        end else begin
            if (ack_req) begin
                LOW_BATT_IRQ  <= 1'b0;
                POWER_OFF_IRQ <= 1'b0;
            end
            step <= step + 4'h1;
            case (state)
            `PWRSEQ_S_OFF: begin
                POWER_ENABLE_OUTPUT_B    <= 1'b1;
                GATE_ARRAY_INIT_OUTPUT_B <= 1'b0;
                PERIPH_POWER             <= 1'b0;
                HEAD_UNLOAD              <= 1'b0;
                WARN_DISPLAY             <= 1'b0;
                if (sw_rise || wake_hit) begin
                    POWER_ENABLE_OUTPUT_B <= 1'b0;
                    step  <= 4'h0;
                    state <= `PWRSEQ_S_RAILON;
                end
            end
            `PWRSEQ_S_RAILON: begin
                if (step == `PWRSEQ_STEP_CYC - 1) begin
                    GATE_ARRAY_INIT_OUTPUT_B <= 1'b1;
                    PERIPH_POWER             <= 1'b1;
                    low_seen                 <= 1'b0;
                    state                    <= `PWRSEQ_S_ON;
                end
            end
            `PWRSEQ_S_ON: begin
                if (sw_fall) begin
                    POWER_OFF_IRQ <= 1'b1;
                    state         <= `PWRSEQ_S_REQ;
                end else if (vbat < vlow_thr && !adc_phase) begin
                    LOW_BATT_IRQ <= 1'b1;
                    low_seen     <= 1'b1;
                    WARN_DISPLAY <= 1'b1;
                    warn_sec     <= 5'h00;
                    state        <= `PWRSEQ_S_WARN;
                end else if (KEY_ENTRY_WAIT && idle_expired) begin
                    POWER_OFF_IRQ <= 1'b1;
                    state         <= `PWRSEQ_S_REQ;
                end
            end
            `PWRSEQ_S_WARN: begin
                if (sec_tick) begin
                    if (warn_sec == `PWRSEQ_WARN_S - 1) begin
                        WARN_DISPLAY <= 1'b0;
                        // Switch already off: its own edge took over
                        if (POWER_SWITCH_IRQ_INPUT) begin
                            POWER_OFF_IRQ <= 1'b1;
                            state         <= `PWRSEQ_S_REQ;
                        end
                    end else begin
                        warn_sec <= warn_sec + 5'h01;
                    end
                end
                if (sw_fall) begin
                    WARN_DISPLAY  <= 1'b0;
                    POWER_OFF_IRQ <= 1'b1;
                    state         <= `PWRSEQ_S_REQ;
                end
            end
            `PWRSEQ_S_REQ: begin
                if (!OP_BUSY && PRINTER_READY) begin
                    HEAD_UNLOAD <= 1'b1;
                    step        <= 4'h0;
                    state       <= `PWRSEQ_S_HEAD;
                end
            end
            `PWRSEQ_S_HEAD: begin
                if (step == `PWRSEQ_STEP_CYC - 1) begin
                    HEAD_UNLOAD  <= 1'b0;
                    PERIPH_POWER <= 1'b0;
                    step         <= 4'h0;
                    state        <= `PWRSEQ_S_PERIPH;
                end
            end
            `PWRSEQ_S_PERIPH: begin
                if (step == `PWRSEQ_STEP_CYC - 1) begin
                    GATE_ARRAY_INIT_OUTPUT_B <= 1'b0;
                    step                     <= 4'h0;
                    state                    <= `PWRSEQ_S_RAILOFF;
                end
            end
            default: begin
                if (step == `PWRSEQ_STEP_CYC - 1) begin
                    POWER_ENABLE_OUTPUT_B <= 1'b1;
                    state                 <= `PWRSEQ_S_OFF;
                end
            end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Charging and auxiliary supplies
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CHARGE_TRICKLE       <= 1'b0;
            LINE_DRIVER_EN       <= 1'b0;
            PROM_REG_EN          <= 1'b0;
            LCD_BIAS_EN          <= 1'b0;
            BACKUP_SOURCE_SELECT <= 1'b0;
        end else begin
            if (!ADAPTER_PRESENT)
                CHARGE_TRICKLE <= 1'b0;
            else if (vbat < vrech_thr)
                CHARGE_TRICKLE <= 1'b0;
            else if ({1'b0, vbat} >= {1'b0, vrech_thr} + 7'h04)
                CHARGE_TRICKLE <= 1'b1;
            LINE_DRIVER_EN <= rail_on && (ctrl[`PWRSEQ_CTRL_SER_USE] ||
                              ctrl[`PWRSEQ_CTRL_HSS_USE]);
            PROM_REG_EN    <= rail_on &&
                              ctrl[`PWRSEQ_CTRL_PROM_ACC];
            // Bias stays up until the rail itself is dropped
            LCD_BIAS_EN    <= (state != `PWRSEQ_S_OFF);
            BACKUP_SOURCE_SELECT <= ctrl[`PWRSEQ_CTRL_BACKUP] ||
                                    low_seen;
        end
    end
endmodule // pwrseq_top

// file: pwrseq_regs.vh
// Purpose: register map, fields and timing counts of the power sequencer
// Assumes: 32-bit AHB-Lite word registers, REF_CLK at 200 MHz
// Notes:   times are held in their own unit; only the second is converted to cycles here
`ifndef PWRSEQ_REGS_VH
`define PWRSEQ_REGS_VH

`define PWRSEQ_CTRL_OFS      12'h000
`define PWRSEQ_STATUS_OFS    12'h004
`define PWRSEQ_WAKE_OFS      12'h008
`define PWRSEQ_TOD_OFS       12'h00C
`define PWRSEQ_AUTOOFF_OFS   12'h010
`define PWRSEQ_VTHR_OFS      12'h014
`define PWRSEQ_ACK_OFS       12'h018

// Control fields
`define PWRSEQ_CTRL_WAKE_EN  0
`define PWRSEQ_CTRL_SER_USE  1
`define PWRSEQ_CTRL_HSS_USE  2
`define PWRSEQ_CTRL_PROM_ACC 3
`define PWRSEQ_CTRL_BACKUP   4
`define PWRSEQ_CTRL_RESET    8'h00

`define PWRSEQ_AUTOOFF_RESET 8'h0A
`define PWRSEQ_VLOW_RESET    6'h26
`define PWRSEQ_VRECH_RESET   6'h2A

// Timing
`define PWRSEQ_CLK_HZ        200000000
`define PWRSEQ_WARN_S        30
`define PWRSEQ_MIN_S         60
`define PWRSEQ_SEC_CYC       (`PWRSEQ_CLK_HZ)
`define PWRSEQ_DAY_S         17'h15180
`define PWRSEQ_STEP_CYC      16

// Sequencer states
`define PWRSEQ_S_OFF     3'h0
`define PWRSEQ_S_RAILON  3'h1
`define PWRSEQ_S_ON      3'h2
`define PWRSEQ_S_WARN    3'h3
`define PWRSEQ_S_REQ     3'h4
`define PWRSEQ_S_HEAD    3'h5
`define PWRSEQ_S_PERIPH  3'h6
`define PWRSEQ_S_RAILOFF 3'h7

`endif

// file: pwrseq_timebase.v
// Purpose: seconds tick and time-of-day counter
// Assumes: one clock, asynchronous active-low reset
// Notes:   time of day is settable and wraps at one day
`timescale 1ns/1ps
`include "pwrseq_regs.vh"

module pwrseq_timebase #(
    parameter SEC_CYC = `PWRSEQ_SEC_CYC
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        tod_load,
    input  wire [16:0] tod_value,
    output reg         sec_tick,
    output reg  [16:0] tod
);
    reg [31:0] pre;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre      <= 32'h00000000;
            sec_tick <= 1'b0;
            tod      <= 17'h00000;
        end else begin
            sec_tick <= 1'b0;
            if (pre >= SEC_CYC - 1) begin
                pre      <= 32'h00000000;
                sec_tick <= 1'b1;
            end else begin
                pre <= pre + 32'h00000001;
            end
            if (tod_load) begin
                tod <= tod_value;
            end else if (pre >= SEC_CYC - 1) begin
                if (tod >= `PWRSEQ_DAY_S - 17'h00001)
                    tod <= 17'h00000;
                else
                    tod <= tod + 17'h00001;
            end
        end
    end
endmodule // pwrseq_timebase

// file: pwrseq_asserts.sv
// Purpose: port-level checks of the power sequencer
// Assumes: bound to pwrseq_top with its SEC_CYC
// Notes:   warning span allows one seconds tick of phase slack
`timescale 1ns/1ps
module pwrseq_asserts #(
    parameter SEC_CYC = 20
) (
    input logic REF_CLK,
    input logic RST_B,
    input logic POWER_SWITCH_IRQ_INPUT,
    input logic OP_BUSY,
    input logic PRINTER_READY,
    input logic POWER_ENABLE_OUTPUT_B,
    input logic GATE_ARRAY_INIT_OUTPUT_B,
    input logic WARN_DISPLAY,
    input logic HEAD_UNLOAD,
    input logic PERIPH_POWER,
    input logic LCD_BIAS_EN,
    input logic ADC_SAMPLE
);
    logic [31:0] warn_len;
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            warn_len <= 32'h0;
        else if (WARN_DISPLAY)
            warn_len <= warn_len + 32'h1;
        else
            warn_len <= 32'h0;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////
    chk_rail_follow: assert property ($rose(POWER_SWITCH_IRQ_INPUT) &&
        POWER_ENABLE_OUTPUT_B && !GATE_ARRAY_INIT_OUTPUT_B
        |-> ##[1:3] !POWER_ENABLE_OUTPUT_B) else $error("rail not enabled");
    chk_ga_release: assert property ($rose(GATE_ARRAY_INIT_OUTPUT_B) |->
        !POWER_ENABLE_OUTPUT_B && $past(POWER_ENABLE_OUTPUT_B, 8) == 1'b0)
        else $error("gate arrays released before rail");
    chk_ga_before_off: assert property ($rose(POWER_ENABLE_OUTPUT_B) |->
        !GATE_ARRAY_INIT_OUTPUT_B && $past(GATE_ARRAY_INIT_OUTPUT_B, 8) == 1'b0)
        else $error("rail dropped with gate arrays free");
    chk_bias_tracks: assert property (
        $past(POWER_ENABLE_OUTPUT_B) == POWER_ENABLE_OUTPUT_B &&
        $past(POWER_ENABLE_OUTPUT_B, 2) == POWER_ENABLE_OUTPUT_B
        |-> LCD_BIAS_EN == !POWER_ENABLE_OUTPUT_B) else $error("bias wrong");
    chk_head_pulse: assert property ($rose(HEAD_UNLOAD) |-> PERIPH_POWER
        ##15 HEAD_UNLOAD ##1 !HEAD_UNLOAD) else $error("head pulse length");
    chk_head_waits: assert property ($rose(HEAD_UNLOAD) |->
        $past(OP_BUSY) == 1'b0 && $past(PRINTER_READY) == 1'b1)
        else $error("off sequence did not wait");
    chk_periph_order: assert property ($fell(PERIPH_POWER) |->
        $past(HEAD_UNLOAD) || $past(HEAD_UNLOAD, 2))
        else $error("peripherals cut before head unload");
    chk_warn_span: assert property ($fell(WARN_DISPLAY) |->
        warn_len > 29 * SEC_CYC && warn_len <= 30 * SEC_CYC + 1)
        else $error("warning span wrong");
    chk_warn_rail: assert property (WARN_DISPLAY |->
        !POWER_ENABLE_OUTPUT_B) else $error("rail off during warning");
    chk_adc_pulse: assert property ($rose(ADC_SAMPLE) |=> !ADC_SAMPLE)
        else $error("sample pulse too long");
endmodule // pwrseq_asserts

bind pwrseq_top pwrseq_asserts #(.SEC_CYC(SEC_CYC)) u_chk (
    .REF_CLK(REF_CLK), .RST_B(RST_B),
    .POWER_SWITCH_IRQ_INPUT(POWER_SWITCH_IRQ_INPUT),
    .OP_BUSY(OP_BUSY), .PRINTER_READY(PRINTER_READY),
    .POWER_ENABLE_OUTPUT_B(POWER_ENABLE_OUTPUT_B),
    .GATE_ARRAY_INIT_OUTPUT_B(GATE_ARRAY_INIT_OUTPUT_B),
    .WARN_DISPLAY(WARN_DISPLAY), .HEAD_UNLOAD(HEAD_UNLOAD),
    .PERIPH_POWER(PERIPH_POWER), .LCD_BIAS_EN(LCD_BIAS_EN),
    .ADC_SAMPLE(ADC_SAMPLE));

// file: pwrseq_host_model.sv
// Purpose: main processor and power switch on the far side
// Assumes: commands from the bench arrive as levels
// Notes:   slow mode stretches the wind-down of running work
`timescale 1ns/1ps
module pwrseq_host_model (
    input  logic clk,
    input  logic rst_b,
    input  logic sw_cmd,
    input  logic busy_cmd,
    input  logic slow,
    input  logic low_batt_irq,
    input  logic power_off_irq,
    output logic power_switch,
    output logic op_busy,
    output logic printer_ready
);
    logic [7:0] wind_cnt;
    logic       done;
    assign done = wind_cnt == (slow ? 8'h40 : 8'h03);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_switch <= 1'b0;
            wind_cnt     <= 8'h00;
        end else begin
            power_switch <= sw_cmd;
            if (!(low_batt_irq || power_off_irq))
                wind_cnt <= 8'h00;
            else if (!done)
                wind_cnt <= wind_cnt + 8'h01;
        end
    end
    // Work ends and printer reinit once told to stop
    assign op_busy       = busy_cmd && !done;
    assign printer_ready = !busy_cmd || done;
endmodule // pwrseq_host_model

// file: testbench.sv
// Purpose: self-checking bench of the power sequencer
// Assumes: SEC_CYC shortened to 20 cycles
// Notes:   register bus is a zero-wait slave, waits still bounded
`timescale 1ns/1ps
`include "pwrseq_regs.vh"
module testbench;
    localparam SC = 20;
    logic REF_CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, rd, v;
    logic [1:0] HTRANS = 0;
    logic [2:0] HSIZE = 0;
    logic [5:0] BATTERY_RAIL = 6'h30;
    logic ADAPTER_PRESENT = 0, IO_ACTIVITY = 0, KEY_ENTRY_WAIT = 0;
    logic sw_cmd = 0, busy_cmd = 0, slow = 0;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, POWER_SWITCH_IRQ_INPUT, OP_BUSY, PRINTER_READY;
    wire PEO_B, GA_B, BACKUP, TRICKLE, LB_IRQ, OFF_IRQ, WARN, HEAD, PERIPH;
    wire LINE_DRV, PROM_EN, BIAS, ADC;
    int n_mismatch = 0, compares = 0, t, i;
    always #2.5 REF_CLK = ~REF_CLK;
    pwrseq_top #(.SEC_CYC(SC)) i_dut (.REF_CLK(REF_CLK), .RST_B(RST_B),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .POWER_SWITCH_IRQ_INPUT(POWER_SWITCH_IRQ_INPUT),
        .ADAPTER_PRESENT(ADAPTER_PRESENT), .BATTERY_RAIL(BATTERY_RAIL),
        .IO_ACTIVITY(IO_ACTIVITY), .KEY_ENTRY_WAIT(KEY_ENTRY_WAIT),
        .OP_BUSY(OP_BUSY), .PRINTER_READY(PRINTER_READY),
        .POWER_ENABLE_OUTPUT_B(PEO_B), .GATE_ARRAY_INIT_OUTPUT_B(GA_B),
        .BACKUP_SOURCE_SELECT(BACKUP), .CHARGE_TRICKLE(TRICKLE),
        .LOW_BATT_IRQ(LB_IRQ), .POWER_OFF_IRQ(OFF_IRQ), .WARN_DISPLAY(WARN),
        .HEAD_UNLOAD(HEAD), .PERIPH_POWER(PERIPH), .LINE_DRIVER_EN(LINE_DRV),
        .PROM_REG_EN(PROM_EN), .LCD_BIAS_EN(BIAS), .ADC_SAMPLE(ADC));
    pwrseq_host_model i_host (.clk(REF_CLK), .rst_b(RST_B), .sw_cmd(sw_cmd),
        .busy_cmd(busy_cmd), .slow(slow), .low_batt_irq(LB_IRQ),
        .power_off_irq(OFF_IRQ), .power_switch(POWER_SWITCH_IRQ_INPUT),
        .op_busy(OP_BUSY), .printer_ready(PRINTER_READY));
    ////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task ahb(input logic wr, input logic [31:0] a, d);
        @(posedge REF_CLK);
        HSEL <= 1; HTRANS <= 2'b10; HADDR <= a; HWRITE <= wr; HSIZE <= 3'h2;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 0; HTRANS <= 2'b00; HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    function logic sig(input int k);
        case (k)
            0: sig = PEO_B;
            1: sig = GA_B;
            2: sig = LB_IRQ;
            3: sig = OFF_IRQ;
            default: sig = TRICKLE;
        endcase
    endfunction
    task wait_for(input int k, input logic val, input int lim);
        t = 0;
        @(posedge REF_CLK); #1;
        while (sig(k) !== val && t < lim) begin
            @(posedge REF_CLK); #1; t++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    initial begin
        cyc(30000);
        n_mismatch++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rd = $urandom(16);
        cyc(20);
        RST_B <= 1;
        check("rail_b", PEO_B, 1);
        check("ga_init_b", GA_B, 0);
        ahb(0, `PWRSEQ_AUTOOFF_OFS, 0);
        check("autooff", rd, `PWRSEQ_AUTOOFF_RESET);
        ahb(0, `PWRSEQ_VTHR_OFS, 0);
        check("vthr", rd, {18'h0, `PWRSEQ_VRECH_RESET, 2'h0, `PWRSEQ_VLOW_RESET});
        ahb(0, 32'h01C, 0);
        check("unmapped", rd, 0);
        check("hresp", HRESP, 0);
        $display("test reset done");
        sw_cmd <= 1;
        wait_for(0, 0, 8);
        check("rail_on", PEO_B, 0);
        check("ga_held", GA_B, 0);
        wait_for(1, 1, 40);
        check("ga_free", GA_B, 1);
        check("bias_on", BIAS, 1);
        $display("test power on done");
        for (i = 0; i < 10; i++) begin
            v = (i < 4) ? (32'h1 << i) : ($urandom & 32'h1E);
            v[0] = 1'b0;
            ahb(1, `PWRSEQ_CTRL_OFS, v);
            cyc(2);
            check("line_drv", LINE_DRV, v[1] | v[2]);
            check("prom_reg", PROM_EN, v[3]);
            check("backup", BACKUP, v[4]);
        end
        ahb(1, `PWRSEQ_CTRL_OFS, 0);
        $display("test supplies done");
        busy_cmd <= 1; slow <= 1; sw_cmd <= 0;
        wait_for(3, 1, 8);
        check("off_irq", OFF_IRQ, 1);
        cyc(30);
        check("off_waits", PEO_B | HEAD, 0);
        wait_for(0, 1, 400);
        check("rail_off", PEO_B, 1);
        check("periph_off", PERIPH, 0);
        check("ga_reset", GA_B, 0);
        ahb(1, `PWRSEQ_ACK_OFS, 1);
        cyc(1);
        check("off_ack", OFF_IRQ, 0);
        check("bias_off", BIAS, 0);
        busy_cmd <= 0;
        $display("test switch off done");
        ahb(1, `PWRSEQ_TOD_OFS, 100);
        ahb(1, `PWRSEQ_WAKE_OFS, 102);
        ahb(1, `PWRSEQ_CTRL_OFS, 1);
        wait_for(0, 0, 3 * SC + 20);
        check("wake_on", PEO_B, 0);
        check("wake_late", t >= SC, 1);
        ahb(1, `PWRSEQ_CTRL_OFS, 0);
        wait_for(1, 1, 40);
        sw_cmd <= 1;
        cyc(4);
        sw_cmd <= 0;
        wait_for(0, 1, 400);
        check("wake_off", PEO_B, 1);
        ahb(1, `PWRSEQ_ACK_OFS, 1);
        $display("test wake done");
        sw_cmd <= 1;
        wait_for(0, 0, 8);
        ahb(1, `PWRSEQ_AUTOOFF_OFS, 255);
        ahb(1, `PWRSEQ_AUTOOFF_OFS, 0);
        ahb(0, `PWRSEQ_AUTOOFF_OFS, 0);
        check("autooff_max", rd, 255);
        ahb(1, `PWRSEQ_AUTOOFF_OFS, 1);
        KEY_ENTRY_WAIT <= 1;
        cyc(50 * SC + $urandom % SC);
        IO_ACTIVITY <= 1;
        cyc(1);
        IO_ACTIVITY <= 0;
        cyc(55 * SC);
        check("idle_restart", PEO_B, 0);
        wait_for(0, 1, 10 * SC + 300);
        check("auto_off", PEO_B, 1);
        KEY_ENTRY_WAIT <= 0; sw_cmd <= 0;
        ahb(1, `PWRSEQ_ACK_OFS, 1);
        $display("test auto off done");
        sw_cmd <= 1;
        wait_for(0, 0, 8);
        busy_cmd <= 1; slow <= 0;
        BATTERY_RAIL <= 6'h20 - 6'($urandom % 8);
        wait_for(2, 1, 2 * SC + 10);
        check("low_irq", LB_IRQ, 1);
        check("warn", WARN, 1);
        cyc(15 * SC);
        check("aux_backup", BACKUP, 1);
        check("warn_rail", PEO_B, 0);
        wait_for(0, 1, 16 * SC + 300);
        check("low_off", PEO_B, 1);
        BATTERY_RAIL <= 6'h30; busy_cmd <= 0; sw_cmd <= 0;
        ahb(1, `PWRSEQ_ACK_OFS, 1);
        $display("test low battery done");
        ADAPTER_PRESENT <= 1;
        BATTERY_RAIL <= 6'h2E + 6'($urandom % 8);
        wait_for(4, 1, 3 * SC);
        check("trickle", TRICKLE, 1);
        BATTERY_RAIL <= 6'h27 + 6'($urandom % 3);
        wait_for(4, 0, 3 * SC);
        check("normal", TRICKLE, 0);
        RST_B <= 0;
        cyc(2);
        RST_B <= 1;
        check("restart", {PEO_B, GA_B}, 2'b10);
        $display("test charge done");
        give_verdict;
    end
endmodule // testbench
